// ===== rtl/swb_pkg.sv
// Package of constants and types for the serial write buffer transmitter
// Contract
// - Auto end: resume, or enter pending interrupt
// - Interactive stream of unlimited length
// - Seamless clock only at slow rates; code: every rate adds one low cycle per nibble
// - Buffer to shifter raises irq, flag
// - Early reload shifts next nibble seamlessly
// - Buffer write clears irq and flag; code: not in start-mode ST_LOAD (both stay set) or at auto end (flag set)
// - Repeat irq until done, clear start
// - Software start clear aborts at once
// - Rate codes 1024/2048/8192/16384 Hz, reset slowest
// - Data changes on rising clock edge
// - Enable plus output mode drives pins
// - Start bit 2, auto bit 3
package swb_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int RATE0_HZ = 1024;
  localparam int RATE1_HZ = 2048;
  localparam int RATE2_HZ = 8192;
  localparam int RATE3_HZ = 16384;
  // Half period counts of the shift clock
  localparam int HALF0 = CLK_HZ / (2 * RATE0_HZ);
  localparam int HALF1 = CLK_HZ / (2 * RATE1_HZ);
  localparam int HALF2 = CLK_HZ / (2 * RATE2_HZ);
  localparam int HALF3 = CLK_HZ / (2 * RATE3_HZ);
  localparam int DIV_W = 16;
  localparam int NIB_W = 4;
  localparam int SIZE_W = 6;
  localparam int BIT_START = 2;
  localparam int BIT_AUTO = 3;
  localparam logic [3:0] BUF_RESET = 4'hf;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic enable;
    logic port_d_out;
    logic [1:0] rate_sel;
  } swb_cfg_t;

  typedef struct packed {
    logic wr;
    logic [3:0] data;
  } swb_nib_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_LOW = 4'b1000
  } swb_state_t;
endpackage

// ===== rtl/swb_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module swb_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

// ===== rtl/swb_tx.sv
// Serial write buffer transmitter top
`timescale 1ns/100ps
module swb_tx
  import swb_pkg::*;
#(
  parameter int HALF_SLOW = HALF0,
  parameter int HALF_2K = HALF1,
  parameter int HALF_8K = HALF2,
  parameter int HALF_16K = HALF3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire swb_cfg_t cfg,
  input wire swb_nib_wr_t buf_wr,
  input wire logic size_wr,
  input wire logic [7:0] size_wdata,
  input wire logic halt,
  input wire logic irq_pending,
  input wire logic ram_valid,
  input wire logic [3:0] ram_data,
  output logic ram_rd,
  output logic [5:0] ram_addr,
  input wire logic fifo_in_valid,
  output logic fifo_in_ready,
  input wire logic [3:0] fifo_in_data,
  output logic [3:0] buffer_q,
  output logic [7:0] size_high_q,
  output logic [3:0] size_low_q,
  output logic jump_test_flag,
  output logic buffer_empty_irq,
  output logic standby,
  output logic resume,
  output logic goto_isr,
  output logic port_d_pin0,
  output logic port_d_pin1,
  output logic port_d_pin0_oe_n,
  output logic port_d_pin1_oe_n
);
  swb_state_t st_r, st_nxt;
  logic [3:0] buf_r, buf_nxt, sh_r, sh_nxt;
  logic buf_full_r, buf_full_nxt;
  logic [5:0] size_r, size_nxt;
  logic auto_r, auto_nxt, start_r, start_nxt;
  logic flag_r, flag_nxt, irq_r, irq_nxt;
  logic [1:0] bit_r, bit_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic clk_r, clk_nxt, dat_r, dat_nxt;
  logic stby_r, stby_nxt, irqseen_r, irqseen_nxt;
  logic res_r, res_nxt, isr_r, isr_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic ram_done_r, ram_done_nxt;
  logic irq_s1_r, irq_s2_r;
  logic f_valid, f_ready;
  logic [3:0] f_data;
  logic [DIV_W-1:0] half;
  logic tick, active;

  // Port-side data staged through FIFO before the buffer register
  swb_fifo #(.WIDTH(NIB_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  function automatic logic [DIV_W-1:0] half_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: half_of = DIV_W'(HALF_SLOW);
      2'h1: half_of = DIV_W'(HALF_2K);
      2'h2: half_of = DIV_W'(HALF_8K);
      default: half_of = DIV_W'(HALF_16K);
    endcase
  endfunction

  assign half = half_of(cfg.rate_sel);
  assign tick = (div_r == half - 1'b1);
  assign active = start_r || (auto_r && stby_r);
  // FIFO refills the buffer only once it has been emptied
  assign f_ready = !buf_wr.wr && !buf_full_r;

  always_comb begin
    st_nxt = st_r;
    buf_nxt = buf_r;
    buf_full_nxt = buf_full_r;
    sh_nxt = sh_r;
    size_nxt = size_r;
    auto_nxt = auto_r;
    start_nxt = start_r;
    flag_nxt = flag_r;
    irq_nxt = irq_r;
    bit_nxt = bit_r;
    div_nxt = (st_r == ST_IDLE || st_r == ST_LOAD || tick) ? '0 : div_r + 1'b1;
    clk_nxt = clk_r;
    dat_nxt = dat_r;
    stby_nxt = stby_r;
    irqseen_nxt = irqseen_r;
    res_nxt = 1'b0;
    isr_nxt = 1'b0;
    addr_nxt = addr_r;
    ram_done_nxt = ram_done_r;
    ram_rd = 1'b0;
    if (buf_wr.wr || (f_valid && f_ready)) begin
      buf_nxt = buf_wr.wr ? buf_wr.data : f_data;
      buf_full_nxt = 1'b1;
    end
    if (buf_wr.wr) begin
      flag_nxt = 1'b0;
      irq_nxt = 1'b0;
    end
    if (size_wr) begin
      size_nxt = {size_wdata[5:4], size_wdata[3:0]};
      auto_nxt = size_wdata[NIB_W + BIT_AUTO];
      start_nxt = size_wdata[NIB_W + BIT_START];
    end
    if (halt && auto_r && !stby_r) begin
      stby_nxt = 1'b1;
      irqseen_nxt = 1'b0;
      addr_nxt = '0;
      ram_done_nxt = 1'b0;
    end
    if (stby_r && irq_s2_r) begin
      irqseen_nxt = 1'b1;
    end
    unique case (st_r)
      ST_IDLE: begin
        clk_nxt = 1'b0;
        if (active && buf_full_r) begin
          st_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        sh_nxt = buf_r;
        buf_full_nxt = buf_wr.wr;
        bit_nxt = 2'h0;
        st_nxt = ST_HIGH;
        if (start_r) begin
          irq_nxt = 1'b1;
          flag_nxt = 1'b1;
        end
        if (auto_r && stby_r && !ram_done_r && ram_valid) begin
          // Prefetch next RAM nibble into the buffer
          ram_rd = 1'b1;
          buf_nxt = ram_data;
          buf_full_nxt = 1'b1;
          ram_done_nxt = (addr_r == size_r);
          addr_nxt = addr_r + 1'b1;
        end
        clk_nxt = 1'b1;
        dat_nxt = buf_r[0];
      end
      ST_HIGH: begin
        if (tick) begin
          clk_nxt = 1'b0;
          st_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tick) begin
          if (bit_r == 2'h3) begin
            if (active && buf_full_r) begin
              st_nxt = ST_LOAD;
            end else begin
              st_nxt = ST_IDLE;
              if (start_r) begin
                start_nxt = 1'b0;
              end
              if (auto_r && stby_r) begin
                auto_nxt = 1'b0;
                stby_nxt = 1'b0;
                flag_nxt = 1'b1;
                res_nxt = !irqseen_r;
                isr_nxt = irqseen_r;
              end
            end
          end else begin
            bit_nxt = bit_r + 1'b1;
            clk_nxt = 1'b1;
            dat_nxt = sh_r[bit_r + 2'h1];
            st_nxt = ST_HIGH;
          end
        end
        if (start_r && !buf_full_r && !buf_wr.wr) begin
          irq_nxt = 1'b1;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (size_wr && !size_wdata[NIB_W + BIT_START] && start_r) begin
      st_nxt = ST_IDLE;
      clk_nxt = 1'b0;
      div_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      buf_r <= BUF_RESET;
      buf_full_r <= 1'b0;
      sh_r <= '0;
      size_r <= '0;
      auto_r <= 1'b0;
      start_r <= 1'b0;
      flag_r <= 1'b0;
      irq_r <= 1'b0;
      bit_r <= '0;
      div_r <= '0;
      clk_r <= 1'b0;
      dat_r <= 1'b0;
      stby_r <= 1'b0;
      irqseen_r <= 1'b0;
      res_r <= 1'b0;
      isr_r <= 1'b0;
      addr_r <= '0;
      ram_done_r <= 1'b0;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      buf_r <= buf_nxt;
      buf_full_r <= buf_full_nxt;
      sh_r <= sh_nxt;
      size_r <= size_nxt;
      auto_r <= auto_nxt;
      start_r <= start_nxt;
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
      clk_r <= clk_nxt;
      dat_r <= dat_nxt;
      stby_r <= stby_nxt;
      irqseen_r <= irqseen_nxt;
      res_r <= res_nxt;
      isr_r <= isr_nxt;
      addr_r <= addr_nxt;
      ram_done_r <= ram_done_nxt;
      irq_s1_r <= irq_pending;
      irq_s2_r <= irq_s1_r;
    end
  end

  assign ram_addr = addr_r;
  assign buffer_q = buf_r;
  assign size_low_q = size_r[3:0];
  assign size_high_q = {4'h0, auto_r, start_r, size_r[5:4]};
  assign jump_test_flag = flag_r;
  assign buffer_empty_irq = irq_r;
  assign standby = stby_r;
  assign resume = res_r;
  assign goto_isr = isr_r;
  // Pins driven only with enable and port D output mode
  assign port_d_pin0 = clk_r;
  assign port_d_pin1 = dat_r;
  assign port_d_pin0_oe_n = !(cfg.enable && cfg.port_d_out);
  assign port_d_pin1_oe_n = !(cfg.enable && cfg.port_d_out);
endmodule

// ===== verification/swb_tx_sva.sv
// Assertion checker for the serial write buffer transmitter
`timescale 1ns/100ps
module swb_tx_sva
  import swb_pkg::*;
#(
  parameter int HALF_SLOW = HALF0,
  parameter int HALF_2K = HALF1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire swb_cfg_t cfg,
  input wire swb_nib_wr_t buf_wr,
  input wire logic size_wr,
  input wire logic [7:0] size_wdata,
  input wire logic [7:0] size_high_q,
  input wire logic jump_test_flag,
  input wire logic buffer_empty_irq,
  input wire logic standby,
  input wire logic resume,
  input wire logic goto_isr,
  input wire logic port_d_pin0,
  input wire logic port_d_pin1,
  input wire logic port_d_pin0_oe_n,
  input wire logic port_d_pin1_oe_n
);
  logic [15:0] hi_r;
  logic [15:0] hi_nxt;
  logic run;
  // Length of the current high phase
  always_comb begin
    hi_nxt = (rst || !port_d_pin0) ? 16'h0 : hi_r + 16'h1;
  end
  always_ff @(posedge core_clk) begin
    hi_r <= hi_nxt;
  end
  assign run = size_high_q[BIT_START] | standby;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_wr_clears: assert property (buf_wr.wr |=> !jump_test_flag && !buffer_empty_irq)
    else $error("buffer write left flags set");
  chk_pin_drive: assert property (cfg.enable && cfg.port_d_out && $past(cfg.enable)
    && $past(cfg.port_d_out) |-> !port_d_pin0_oe_n && !port_d_pin1_oe_n)
    else $error("pins not driven");
  chk_idle_low: assert property (!run && !$past(size_high_q[BIT_START])
    && !$past(standby) |-> !port_d_pin0) else $error("clock not idle low");
  chk_data_rise: assert property (run && $past(run) && $changed(port_d_pin1)
    |-> $rose(port_d_pin0)) else $error("data moved off rising edge");
  chk_half_len: assert property ($fell(port_d_pin0) && !cfg.rate_sel[1]
    |-> hi_r == (cfg.rate_sel[0] ? HALF_2K : HALF_SLOW)) else $error("bad half period");
  chk_irq_flag: assert property ($rose(buffer_empty_irq) |-> jump_test_flag)
    else $error("irq without flag");
  chk_flag_hold: assert property (jump_test_flag && !buf_wr.wr |=> jump_test_flag)
    else $error("flag dropped without write");
  chk_auto_end: assert property (resume || goto_isr |-> !(resume && goto_isr)
    ##[0:2] jump_test_flag) else $error("bad auto end");
  chk_abort_now: assert property (size_wr && !size_wdata[6] && !standby
    |=> !size_high_q[BIT_START] ##[0:1] !port_d_pin0) else $error("abort too slow");
  cov_resume: cover property (resume);
  cov_isr: cover property (goto_isr);
  cov_irq: cover property ($rose(buffer_empty_irq));
endmodule

bind swb_tx swb_tx_sva #(.HALF_SLOW(HALF_SLOW), .HALF_2K(HALF_2K)) u_sva (
  .core_clk(core_clk), .rst(rst), .cfg(cfg), .buf_wr(buf_wr), .size_wr(size_wr),
  .size_wdata(size_wdata), .size_high_q(size_high_q), .jump_test_flag(jump_test_flag),
  .buffer_empty_irq(buffer_empty_irq), .standby(standby), .resume(resume),
  .goto_isr(goto_isr), .port_d_pin0(port_d_pin0), .port_d_pin1(port_d_pin1),
  .port_d_pin0_oe_n(port_d_pin0_oe_n), .port_d_pin1_oe_n(port_d_pin1_oe_n)
);

// ===== verification/swb_rx_model.sv
// Serial receiver model sampling data on falling shift clock
`timescale 1ns/100ps
module swb_rx_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic flush,
  output logic nib_valid,
  output logic [3:0] nib
);
  logic sclk_d;
  logic [3:0] sh;
  int cnt;
  always @(posedge core_clk) begin
    sclk_d <= sclk;
    nib_valid <= 1'b0;
    if (rst || flush) begin
      cnt <= 0;
    end else if (sclk_d && !sclk) begin
      sh <= {sdata, sh[3:1]};
      cnt <= (cnt == 3) ? 0 : cnt + 1;
      if (cnt == 3) begin
        nib <= {sdata, sh[3:1]};
        nib_valid <= 1'b1;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the serial write buffer transmitter
`timescale 1ns/100ps
module testbench;
  import swb_pkg::*;
  logic core_clk, rst, size_wr, halt, irq_pending, fifo_in_valid, flush, nib_valid;
  swb_cfg_t cfg;
  swb_nib_wr_t buf_wr;
  logic [7:0] size_wdata, size_high_q;
  logic [3:0] ram_data, fifo_in_data, buffer_q, size_low_q, d, nib;
  logic [3:0] ram_mem [64];
  logic [5:0] ram_addr;
  logic fifo_in_ready, jump_test_flag, buffer_empty_irq, standby, resume, goto_isr;
  logic port_d_pin0, port_d_pin1, port_d_pin0_oe_n, port_d_pin1_oe_n;
  logic [3:0] exp_q[$];
  int err_total, tests_run, cyc, k, r, n;
  assign ram_data = ram_mem[ram_addr];
  swb_tx #(.HALF_SLOW(4), .HALF_2K(4), .HALF_8K(2), .HALF_16K(2)) dut (
    .core_clk(core_clk), .rst(rst), .cfg(cfg), .buf_wr(buf_wr), .size_wr(size_wr),
    .size_wdata(size_wdata), .halt(halt), .irq_pending(irq_pending), .ram_valid(1'b1),
    .ram_data(ram_data), .ram_rd(), .ram_addr(ram_addr), .fifo_in_valid(fifo_in_valid),
    .fifo_in_ready(fifo_in_ready), .fifo_in_data(fifo_in_data), .buffer_q(buffer_q),
    .size_high_q(size_high_q), .size_low_q(size_low_q), .jump_test_flag(jump_test_flag),
    .buffer_empty_irq(buffer_empty_irq), .standby(standby), .resume(resume),
    .goto_isr(goto_isr), .port_d_pin0(port_d_pin0), .port_d_pin1(port_d_pin1),
    .port_d_pin0_oe_n(port_d_pin0_oe_n), .port_d_pin1_oe_n(port_d_pin1_oe_n)
  );
  swb_rx_model rx (.core_clk(core_clk), .rst(rst), .sclk(port_d_pin0),
    .sdata(port_d_pin1), .flush(flush), .nib_valid(nib_valid), .nib(nib));
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_buf(input logic [3:0] v);
    buf_wr = {1'b1, v};
    tick(1);
    buf_wr.wr = 1'b0;
  endtask
  task automatic wr_size(input logic [7:0] v);
    size_wdata = v;
    size_wr = 1'b1;
    tick(1);
    size_wr = 1'b0;
  endtask
  task automatic end_stream();
    for (k = 0; k < 3000 && size_high_q[2]; k++) tick(1);
    check("stream end", 8'h1, {size_high_q[2], jump_test_flag});
    wr_buf(4'h0);
    check("dummy write", 8'h0, {jump_test_flag, buffer_empty_irq});
  endtask
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // Timeout guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  // Scoreboard: oldest expected nibble against each received one
  always @(posedge core_clk) begin
    if (nib_valid && exp_q.size() == 0) check("stray nibble", 8'h0, 8'h1);
    else if (nib_valid) check("nibble", {4'h0, exp_q.pop_front()}, {4'h0, nib});
  end
  initial begin
    {rst, size_wr, halt, irq_pending, fifo_in_valid, flush} = 6'h20;
    {cfg, buf_wr, size_wdata, fifo_in_data} = '0;
    void'($urandom(78));
    foreach (ram_mem[i]) ram_mem[i] = 4'($urandom);
    tick(8);
    rst = 1'b0;
    tick(1);
    check("reset regs", 8'hf0, {buffer_q, size_low_q});
    check("reset flags", 8'h0, {jump_test_flag, buffer_empty_irq, standby, port_d_pin0});
    cfg = '{1'b1, 1'b1, 2'h0};
    tick(2);
    check("pin enable", 8'h0, {port_d_pin0_oe_n, port_d_pin1_oe_n});
    // Fill the FIFO until it refuses, then stream it out
    for (n = 0; n < 40 && fifo_in_ready; n++) begin
      d = 4'($urandom);
      {fifo_in_valid, fifo_in_data} = {1'b1, d};
      exp_q.push_back(d);
      tick(1);
    end
    fifo_in_valid = 1'b0;
    check("fifo depth", 8'h1, {7'h0, n >= FIFO_DEPTH});
    wr_size(8'h40);
    check("start bit", 8'h04, size_high_q & 8'h0c);
    end_stream();
    for (r = 0; r < 4; r++) begin
      cfg.rate_sel = 2'(r);
      for (n = 0; n < 3; n++) begin
        d = 4'($urandom);
        for (k = 0; n > 0 && k < 500 && !buffer_empty_irq; k++) tick(1);
        check("irq flag", n == 0 ? 8'h0 : 8'h3, {6'h0, buffer_empty_irq, jump_test_flag});
        wr_buf(d);
        exp_q.push_back(d);
        if (n == 0 || r > 1) wr_size(8'h40);
      end
      end_stream();
    end
    cfg.rate_sel = 2'h3;
    wr_buf(4'($urandom));
    wr_size(8'h40);
    for (k = 0; k < 50 && !port_d_pin0; k++) tick(1);
    wr_size(8'h00);
    tick(1);
    check("abort", 8'h0, {size_high_q[2], port_d_pin0});
    flush = 1'b1;
    wr_buf(4'h0);
    flush = 1'b0;
    for (r = 0; r < 2; r++) begin
      irq_pending = r[0];
      d = 4'($urandom);
      wr_buf(d);
      exp_q.push_back(d);
      for (n = 0; n <= 2; n++) exp_q.push_back(ram_mem[n]);
      wr_size(8'h82);
      check("auto bit", 8'h08, size_high_q & 8'h0c);
      halt = 1'b1;
      tick(1);
      halt = 1'b0;
      for (k = 0; k < 400 && !(resume || goto_isr); k++) tick(1);
      check("auto end", 8'(1 << r), {goto_isr, resume});
      tick(2);
      check("auto flag", 8'h4, {jump_test_flag, size_high_q[3], standby});
      wr_buf(4'h0);
    end
    tick(20);
    check("left over", 8'h0, 8'(exp_q.size()));
    final_report();
  end
endmodule
